// *** hdl/wdt_control.sv ***
// What this block does
// - Bit 7 of the control register stops (0) or runs (1) the counter.
// - Bits 5 and 4 select the time-out counter width; bit 6 is reserved.
// - Select code 11 runs the counter at its full 26 bits.
// - With the interrupt enabled, time-out sets the flag in bit 3.
// - Without the interrupt enabled, the flag still records time-out until cleared.
// - A watchdog reset sets the cause flag in bit 2; software clears it.
// - Power-fail and power-on resets clear the cause flag.
// - With reset disabled the watchdog never changes the cause flag.
// - Bit 1 allows (1) or blocks (0) the watchdog chip reset.
// - Writing 1 to bit 0 restarts the counter, cancelling pending time-out.
// - Time-out raises interrupt; chip reset follows 512 clocks later if enabled.
// - The restart bit clears itself and reads back as 0.
// - Reset loads the documented pattern; source-dependent bits follow their own rules.
// - An external pin reset leaves the time-out flag unchanged.
// - Reset enable clears only on power-on reset, kept through others.
// - All bits readable; bits 3,1,0 writable only after a timed-access unlock.
// - The control register sits at D8 and accepts single-bit writes.
`timescale 1ns/1ns
module wdt_control
	import wdt_pkg::*;
#(
	parameter int CNT_W = WDT_CNT_W
)(
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  wire wdt_pkg::wdt_rst_src_type rst_src,
	input  wire wdt_pkg::wdt_sfr_req_type sfr_req,
	input  wire logic [7:0]              sfr_bit_mask,
	input  wire logic                    dog_irq_enable,
	output logic [7:0]                   sfr_rdata,
	output logic                         dog_irq,
	output logic                         chip_reset_req
);
	import wdt_pkg::*;

	logic              dog_run_reg;
	logic [1:0]        period_sel_reg;
	logic              timeout_irq_flag_reg;
	logic              dog_reset_cause_flag_reg;
	logic              dog_reset_enable_reg;
	logic              restart_reg;
	wdt_key_state_type key_state_reg;
	wdt_key_state_type key_state_next;
	logic [1:0]        key_timer_reg;
	logic [9:0]        delay_reg;
	logic              delay_active_reg;
	logic              chip_reset_reg;
	logic              src_seen_reg;
	logic              timeout;
	logic              wr_ctrl;
	logic              wr_key;
	logic              unlocked;
	logic              prot_wr;
	logic [7:0]        wmask;
	logic [7:0]        cur_val;
	logic [7:0]        new_val;
	logic              fire_reset;

	assign wr_ctrl = sfr_req.wr && (sfr_req.addr == WDT_ADDR_CONTROL);
	assign wr_key  = sfr_req.wr && (sfr_req.addr == WDT_ADDR_KEY);
	// Bit mask lets a single-bit set or clear touch only its own field
	assign wmask   = sfr_bit_mask;
	assign unlocked = (key_state_reg == WDT_KEY_OPEN);
	assign prot_wr  = wr_ctrl && unlocked;

	assign cur_val = {dog_run_reg, 1'b0, period_sel_reg, timeout_irq_flag_reg,
	                  dog_reset_cause_flag_reg, dog_reset_enable_reg, 1'b0};
	assign new_val = (cur_val & ~wmask) | (sfr_req.wdata & wmask);
	// Restart bit reads as 0 at all times; its write is a one-shot pulse
	assign sfr_rdata = cur_val;

	wdt_timeout_counter #(
		.CNT_W (CNT_W)
	) u_counter (
		.mclk    (mclk),
		.rst     (rst),
		.run     (dog_run_reg),
		.restart (restart_reg),
		.sel     (period_sel_reg),
		.timeout (timeout)
	);

	assign dog_irq = timeout_irq_flag_reg && dog_irq_enable;
	assign fire_reset = delay_active_reg && (delay_reg == WDT_RESET_DELAY - 10'h1)
	                    && dog_reset_enable_reg;
	assign chip_reset_req = chip_reset_reg;

	// Key sequence: AA then 55 opens a short window; any other key byte rearms
	always_comb
	begin
		key_state_next = key_state_reg;
		case (key_state_reg)
			WDT_KEY_IDLE:
				if (wr_key && sfr_req.wdata == WDT_KEY_FIRST)
					key_state_next = WDT_KEY_GOT_FIRST;
			WDT_KEY_GOT_FIRST:
				if (wr_key)
					key_state_next = (sfr_req.wdata == WDT_KEY_SECOND) ?
					                 WDT_KEY_OPEN : WDT_KEY_IDLE;
			WDT_KEY_OPEN:
				if (wr_ctrl || wr_key || key_timer_reg == 2'h0)
					key_state_next = WDT_KEY_IDLE;
			default:
				key_state_next = WDT_KEY_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			key_state_reg <= WDT_KEY_IDLE;
			key_timer_reg <= 2'h0;
		end
		else
		begin
			key_state_reg <= key_state_next;
			if (key_state_next == WDT_KEY_OPEN && key_state_reg != WDT_KEY_OPEN)
				key_timer_reg <= WDT_KEY_WINDOW;
			else if (key_timer_reg != 2'h0)
				key_timer_reg <= key_timer_reg - 2'h1;
		end
	end

	// Plain control bits take the reset pattern on every reset
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			dog_run_reg    <= WDT_CONTROL_RESET[WDT_BIT_RUN];
			period_sel_reg <= WDT_CONTROL_RESET[WDT_BIT_SEL_HI:WDT_BIT_SEL_LO];
			restart_reg    <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				dog_run_reg    <= new_val[WDT_BIT_RUN];
				period_sel_reg <= new_val[WDT_BIT_SEL_HI:WDT_BIT_SEL_LO];
			end
			restart_reg <= prot_wr && wmask[WDT_BIT_RESTART]
			               && sfr_req.wdata[WDT_BIT_RESTART];
		end
	end

	// Delay from time-out to chip reset; restart cancels it
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			delay_reg        <= 10'h0;
			delay_active_reg <= 1'b0;
			chip_reset_reg   <= 1'b0;
		end
		else
		begin
			chip_reset_reg <= fire_reset;
			if (restart_reg || fire_reset)
			begin
				delay_active_reg <= 1'b0;
				delay_reg        <= 10'h0;
			end
			else if (timeout && !delay_active_reg)
			begin
				delay_active_reg <= 1'b1;
				delay_reg        <= 10'h0;
			end
			else if (delay_active_reg)
				delay_reg <= delay_reg + 10'h1;
		end
	end

	// Source-dependent bits: rst is held asynchronously, so these are
	// updated from rst_src on the clock while rst stands, not by the async path.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			src_seen_reg <= 1'b1;
			if (rst_src == WDT_RST_POWER_ON)
				dog_reset_enable_reg <= 1'b0;
			if (rst_src == WDT_RST_POWER_ON || rst_src == WDT_RST_POWER_FAIL)
			begin
				dog_reset_cause_flag_reg <= 1'b0;
				timeout_irq_flag_reg     <= 1'b0;
			end
			else if (rst_src == WDT_RST_WATCHDOG && dog_reset_enable_reg)
			begin
				dog_reset_cause_flag_reg <= 1'b1;
				timeout_irq_flag_reg     <= 1'b0;
			end
			// External reset keeps the time-out flag
		end
		else
		begin
			src_seen_reg <= 1'b0;
			// Hardware set wins over a same-cycle software clear
			if (timeout)
				timeout_irq_flag_reg <= 1'b1;
			else if (prot_wr)
				timeout_irq_flag_reg <= new_val[WDT_BIT_IRQF];
			if (prot_wr)
				dog_reset_enable_reg <= new_val[WDT_BIT_RST_EN];
			if (wr_ctrl)
				dog_reset_cause_flag_reg <= new_val[WDT_BIT_CAUSE];
		end
	end
endmodule : wdt_control

// *** hdl/wdt_pkg.sv ***
package wdt_pkg;

	localparam logic [7:0] WDT_ADDR_CONTROL = 8'hD8;
	localparam logic [7:0] WDT_ADDR_KEY     = 8'hC7;
	localparam logic [7:0] WDT_KEY_FIRST    = 8'hAA;
	localparam logic [7:0] WDT_KEY_SECOND   = 8'h55;

	localparam int WDT_BIT_RUN     = 7;
	localparam int WDT_BIT_SEL_HI  = 5;
	localparam int WDT_BIT_SEL_LO  = 4;
	localparam int WDT_BIT_IRQF    = 3;
	localparam int WDT_BIT_CAUSE   = 2;
	localparam int WDT_BIT_RST_EN  = 1;
	localparam int WDT_BIT_RESTART = 0;

	// Counter widths per period select code 00..11
	localparam int WDT_WIDTH_SEL0 = 17;
	localparam int WDT_WIDTH_SEL1 = 20;
	localparam int WDT_WIDTH_SEL2 = 23;
	localparam int WDT_WIDTH_SEL3 = 26;
	localparam int WDT_CNT_W      = 26;

	localparam int WDT_RESET_DELAY_CLKS = 512;
	localparam logic [9:0] WDT_RESET_DELAY = 10'(WDT_RESET_DELAY_CLKS);
	localparam int WDT_KEY_WINDOW_CLKS = 3;
	localparam logic [1:0] WDT_KEY_WINDOW = 2'(WDT_KEY_WINDOW_CLKS);

	// Reset pattern for plain control bits (run, select, restart)
	localparam logic [7:0] WDT_CONTROL_RESET = 8'h00;

	typedef enum logic [1:0] {
		WDT_RST_POWER_ON = 2'h0,
		WDT_RST_POWER_FAIL = 2'h1,
		WDT_RST_EXTERNAL = 2'h2,
		WDT_RST_WATCHDOG = 2'h3
	} wdt_rst_src_type;

	typedef enum logic [1:0] {
		WDT_KEY_IDLE = 2'h0,
		WDT_KEY_GOT_FIRST = 2'h1,
		WDT_KEY_OPEN = 2'h2
	} wdt_key_state_type;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} wdt_sfr_req_type;

endpackage : wdt_pkg

// *** hdl/wdt_timeout_counter.sv ***
`timescale 1ns/1ns
module wdt_timeout_counter
	import wdt_pkg::*;
#(
	parameter int CNT_W = WDT_CNT_W
)(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        run,
	input  wire logic        restart,
	input  wire logic [1:0]  sel,
	output logic             timeout
);
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic [CNT_W-1:0] limit;

	// Each select code picks which counter width rolls over
	assign limit = (sel == 2'h3) ? {CNT_W{1'b1}} :
	               (sel == 2'h2) ? CNT_W'((64'h1 << WDT_WIDTH_SEL2) - 64'h1) :
	               (sel == 2'h1) ? CNT_W'((64'h1 << WDT_WIDTH_SEL1) - 64'h1) :
	                               CNT_W'((64'h1 << WDT_WIDTH_SEL0) - 64'h1);
	assign timeout = run && !restart && (count_reg == limit);
	assign count_next = (restart || count_reg >= limit) ? '0 :
	                    run ? count_reg + CNT_W'(1) : count_reg;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end
endmodule : wdt_timeout_counter

// *** verif/wdt_control_monitor.sv ***
`timescale 1ns/1ns
module wdt_monitor (
	input wire logic                     mclk,
	input wire logic                     rst,
	input wire wdt_pkg::wdt_rst_src_type rst_src,
	input wire wdt_pkg::wdt_sfr_req_type sfr_req,
	input wire logic [7:0]               sfr_bit_mask,
	input wire logic                     dog_irq_enable,
	input wire logic [7:0]               sfr_rdata,
	input wire logic                     dog_irq,
	input wire logic                     chip_reset_req
);
	import wdt_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire wr_ctl = sfr_req.wr && sfr_req.addr == WDT_ADDR_CONTROL;
	irq_level_a: assert property (dog_irq == (sfr_rdata[3] && dog_irq_enable))
		else $error("irq differs from flag and enable");
	run_write_a: assert property (wr_ctl && sfr_bit_mask[7] |=>
		sfr_rdata[7] == $past(sfr_req.wdata[7])) else $error("run bit not written");
	sel_write_a: assert property (wr_ctl && sfr_bit_mask[5] && sfr_bit_mask[4] |=>
		sfr_rdata[5:4] == $past(sfr_req.wdata[5:4])) else $error("select not written");
	zero_bits_a: assert property (!sfr_rdata[6] && !sfr_rdata[0])
		else $error("reserved or restart bit reads 1");
	pulse_one_a: assert property (chip_reset_req |=> !chip_reset_req)
		else $error("reset request longer than one cycle");
	rst_gate_a: assert property (chip_reset_req |-> sfr_rdata[1])
		else $error("reset request while disabled");
	stop_flag_a: assert property ($rose(sfr_rdata[3]) && !$past(sfr_req.wr) |->
		$past(sfr_rdata[7])) else $error("time-out while stopped");
	cause_hold_a: assert property (!sfr_rdata[1] && !sfr_req.wr |=> $stable(sfr_rdata[2]))
		else $error("cause flag changed while reset disabled");
	flag_hold_a: assert property (sfr_rdata[3] && !sfr_req.wr |=> sfr_rdata[3])
		else $error("time-out flag dropped without a write");
endmodule : wdt_monitor
bind wdt_control wdt_monitor wdt_monitor_inst (.mclk, .rst, .rst_src, .sfr_req,
	.sfr_bit_mask, .dog_irq_enable, .sfr_rdata, .dog_irq, .chip_reset_req);

// *** verif/wdt_control_tb.sv ***
`timescale 1ns/1ns
module wdt_control_tb;
	import wdt_pkg::*;
	logic            mclk = 1'b0;
	logic            rst = 1'b1;
	wdt_rst_src_type rst_src = WDT_RST_POWER_ON;
	wdt_sfr_req_type sfr_req = '0;
	logic [7:0]      sfr_bit_mask = 8'hFF;
	logic            dog_irq_enable = 1'b1;
	logic [7:0]      sfr_rdata;
	logic            dog_irq;
	logic            chip_reset_req;
	int              err_total = 0;
	int              tests_run = 0;
	int              n;
	logic            f;
	always #50 mclk = ~mclk;
	// Short counter keeps each time-out within a few hundred cycles
	wdt_control #(.CNT_W(8)) wdt_control_inst (.mclk, .rst, .rst_src, .sfr_req,
		.sfr_bit_mask, .dog_irq_enable, .sfr_rdata, .dog_irq, .chip_reset_req);
	task automatic finish_test;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask : chk
	// Idle cycle before each write so the strobe never drops and rises in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
		@(posedge mclk);
		#10;
		sfr_req = '{1'b1, a, d};
		sfr_bit_mask = m;
		@(posedge mclk);
		#10;
		sfr_req.wr = 1'b0;
	endtask : wr
	task automatic key(input logic [7:0] b);
		wr(WDT_ADDR_KEY, WDT_KEY_FIRST, 8'hFF);
		wr(WDT_ADDR_KEY, b, 8'hFF);
	endtask : key
	task automatic do_rst(input wdt_rst_src_type s);
		@(posedge mclk);
		#10;
		rst = 1'b1;
		rst_src = s;
		repeat (3) @(posedge mclk);
		#10;
		rst = 1'b0;
	endtask : do_rst
	task automatic wait_irq;
		n = 0;
		while (sfr_rdata[3] !== 1'b1 && n < 5000)
		begin
			@(posedge mclk);
			#10;
			n++;
		end
	endtask : wait_irq
	initial
	begin
		repeat (20) @(posedge mclk);
		#10;
		rst = 1'b0;
		chk("reset", 8'h00, sfr_rdata);
		wr(WDT_ADDR_CONTROL, 8'hFF, 8'hFF);
		chk("plain", 8'hB4, sfr_rdata);
		wr(WDT_ADDR_CONTROL, 8'h00, 8'hFF);
		key(WDT_KEY_SECOND);
		wr(WDT_ADDR_CONTROL, 8'h02, 8'h02);
		chk("unlock", 8'h02, sfr_rdata);
		wr(WDT_ADDR_CONTROL, 8'h00, 8'h02);
		chk("one shot", 8'h02, sfr_rdata);
		key(8'h12);
		wr(WDT_ADDR_KEY, WDT_KEY_SECOND, 8'hFF);
		wr(WDT_ADDR_CONTROL, 8'h00, 8'h02);
		chk("bad key", 8'h02, sfr_rdata);
		wr(WDT_ADDR_CONTROL, 8'h80, 8'hF0);
		key(WDT_KEY_SECOND);
		wr(WDT_ADDR_CONTROL, 8'h01, 8'h01);
		chk("restart", 8'h82, sfr_rdata);
		wait_irq();
		chk("irq", 8'h01, 8'(dog_irq));
		n = 0;
		while (chip_reset_req !== 1'b1 && n < 600)
		begin
			@(posedge mclk);
			#10;
			n++;
		end
		chk("delay", 8'h01, 8'(n >= 511 && n <= 513));
		do_rst(WDT_RST_WATCHDOG);
		chk("wdog rst", 8'h03, 8'(sfr_rdata[2:1]));
		// Set the flag first so the external reset has something to keep
		key(WDT_KEY_SECOND);
		wr(WDT_ADDR_CONTROL, 8'h08, 8'h08);
		f = sfr_rdata[3];
		chk("flag set", 8'h01, 8'(f));
		do_rst(WDT_RST_EXTERNAL);
		chk("ext rst", 8'h0E, sfr_rdata);
		do_rst(WDT_RST_POWER_FAIL);
		chk("pfail", 8'h02, sfr_rdata);
		do_rst(WDT_RST_POWER_ON);
		chk("pon", 8'h00, sfr_rdata);
		dog_irq_enable = 1'b0;
		wr(WDT_ADDR_CONTROL, 8'h80, 8'hF0);
		wait_irq();
		chk("flag", 8'h88, sfr_rdata);
		chk("irq off", 8'h00, 8'(dog_irq));
		n = 0;
		repeat (600)
		begin
			@(posedge mclk);
			#10;
			if (chip_reset_req !== 1'b0)
				n++;
		end
		chk("no rst", 8'h00, 8'(n));
		chk("cause kept", 8'h00, 8'(sfr_rdata[2]));
		finish_test();
	end
	initial
	begin
		#3000000;
		err_total++;
		finish_test();
	end
endmodule : wdt_control_tb
